// >>> adcpm_ctrl.sv
`timescale 1ns/100ps
// Contract
// - mode chosen only by chip select timing
// - rise after tenth: stay powered; abort only if before the last conversion edge
// - rise between second and tenth: power down
// - power-down aborts conversion, releases output
// - rise before second edge keeps normal
// - power-down removes all analog power
// - select fall wakes; needs ten edges
// - dummy conversion; sixteen clocks, next valid
// - early rise during wake returns down
// - analog ready within one microsecond
// - wake: track on fifth falling edge
// - dummy acquires channel chosen in it
// - supply start: hold, track on fifth
// - select fall: hold, drive output, convert
// - only third input bit picks channel
// - word: zeros, channel twice, result; trailing zeros only in 10-bit
module adcpm_ctrl
	import adcpm_pkg::*;
#(
	parameter int unsigned RES_BITS = 12
) (
	input  wire logic        sys_clk_i,
	input  wire logic        resetn_i,
	input  wire logic        cs_n_i,
	input  wire logic        sclk_i,
	input  wire logic        din_i,
	input  wire logic [11:0] conv_data_i,
	output logic             dout_o,
	output logic             dout_oe_o,
	output logic             track_o,
	output logic             acq_chan_o,
	output logic             analog_pwr_o,
	output logic             pwr_ready_o,
	output logic             conv_start_o,
	output logic             conv_done_o,
	output logic             conv_abort_o,
	output logic             dummy_o,
	output logic             mode_down_o
);
	localparam logic [4:0] CONV_EDGES = (RES_BITS == 12) ? CONV_EDGES_12 : CONV_EDGES_10;

	adcpm_pins_t pins_raw;
	adcpm_pins_t pins_s;
	adcpm_pins_t pins_q;

	adcpm_mode_t           mode_q,     mode_d;
	logic [CNT_W-1:0]      cnt_q,      cnt_d;
	logic                  frame_q,    frame_d;
	logic                  dummy_q,    dummy_d;
	logic                  dout_q,     dout_d;
	logic                  oe_q,       oe_d;
	logic                  track_q,    track_d;
	logic                  next_ch_q,  next_ch_d;
	logic                  conv_ch_q,  conv_ch_d;
	logic                  start_q,    start_d;
	logic                  done_q,     done_d;
	logic                  abort_q,    abort_d;
	logic [PWR_CNT_W-1:0]  pwr_cnt_q,  pwr_cnt_d;
	logic                  cs_fall;
	logic                  cs_rise;
	logic                  sclk_fall;
	logic                  sclk_rise;
	logic [CNT_W-1:0]      cnt_inc;
	logic [15:0]           word;

	assign pins_raw.cs_n = cs_n_i;
	assign pins_raw.sclk = sclk_i;
	assign pins_raw.din  = din_i;

	// all three pins come from the master's domain
	adcpm_sync #(
		.WIDTH (3)
	) u_sync (
		.sys_clk_i (sys_clk_i),
		.resetn_i  (resetn_i),
		.async_i   (pins_raw),
		.rst_val_i (3'b100),
		.sync_o    (pins_s)
	);

	assign cs_fall   = pins_q.cs_n & ~pins_s.cs_n;
	assign cs_rise   = ~pins_q.cs_n & pins_s.cs_n;
	assign sclk_fall = pins_q.sclk & ~pins_s.sclk & ~pins_s.cs_n;
	assign sclk_rise = ~pins_q.sclk & pins_s.sclk & ~pins_s.cs_n;
	assign cnt_inc   = (cnt_q == CNT_MAX) ? cnt_q : cnt_q + 5'h01;

	// output word shape depends on the resolution variant
	always_comb
	begin
		if (RES_BITS == 12)
			word = {2'b00, conv_ch_q, conv_ch_q, conv_data_i};
		else
			word = {2'b00, conv_ch_q, conv_ch_q, conv_data_i[11:2], 2'b00};
	end

	always_comb
	begin
		mode_d    = mode_q;
		cnt_d     = cnt_q;
		frame_d   = frame_q;
		dummy_d   = dummy_q;
		dout_d    = dout_q;
		oe_d      = oe_q;
		track_d   = track_q;
		next_ch_d = next_ch_q;
		conv_ch_d = conv_ch_q;
		start_d   = 1'b0;
		done_d    = 1'b0;
		abort_d   = 1'b0;
		if (cs_fall)
		begin
			// mode control comes from chip select alone; din only picks the channel
			cnt_d     = '0;
			frame_d   = 1'b1;
			track_d   = 1'b0;
			oe_d      = 1'b1;
			dout_d    = 1'b0;
			start_d   = 1'b1;
			conv_ch_d = next_ch_q;
			dummy_d   = (mode_q != ST_NORMAL);
			if (mode_q == ST_DOWN)
				mode_d = ST_WAKE;
		end
		else if (cs_rise && frame_q)
		begin
			frame_d = 1'b0;
			oe_d    = 1'b0;
			if (oe_q && cnt_q < CONV_EDGES)
				abort_d = 1'b1;
			unique case (mode_q)
				ST_NORMAL:
					if (cnt_q >= PD_LO_EDGE && cnt_q < KEEP_EDGE)
						mode_d = ST_DOWN;
				ST_WAKE:
					mode_d = (cnt_q >= KEEP_EDGE) ? ST_NORMAL : ST_DOWN;
				ST_DOWN:
					mode_d = ST_DOWN;
			endcase
			// a sleeping part keeps its sampler in hold, even after a failed wake
			if (mode_d == ST_DOWN)
				track_d = 1'b0;
		end
		else if (sclk_fall && frame_q)
		begin
			cnt_d = cnt_inc;
			if (cnt_inc == CHAN_EDGE)
				next_ch_d = pins_s.din;
			if (cnt_inc == WAKE_TRACK_EDGE && dummy_q)
				track_d = 1'b1;
			if (cnt_inc == FULL_UP_EDGE && mode_q == ST_WAKE)
				mode_d = ST_NORMAL;
			if (cnt_inc == CONV_EDGES && !dummy_q && oe_q)
				done_d = 1'b1;
			if (cnt_inc >= DOUT_END_EDGE)
				oe_d = 1'b0;
			else
				dout_d = word[WORD_TOP - cnt_inc[3:0]];
		end
		else if (sclk_rise && frame_q && cnt_q >= TRACK_EDGE)
			track_d = 1'b1;
	end

	// hold the 1 us power-up against a counter; sclk rate does not matter
	always_comb
	begin
		if (mode_q == ST_DOWN && !frame_q)
			pwr_cnt_d = '0;
		else if (pwr_cnt_q < PWR_CNT_W'(PWR_UP_CYC))
			pwr_cnt_d = pwr_cnt_q + 8'h01;
		else
			pwr_cnt_d = pwr_cnt_q;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!resetn_i)
		begin
			// either mode is legal at supply start; down plus hold mirrors a cold start
			mode_q    <= ST_DOWN;
			cnt_q     <= '0;
			frame_q   <= 1'b0;
			dummy_q   <= 1'b1;
			dout_q    <= 1'b0;
			oe_q      <= 1'b0;
			track_q   <= 1'b0;
			next_ch_q <= RST_CHAN;
			conv_ch_q <= RST_CHAN;
			start_q   <= 1'b0;
			done_q    <= 1'b0;
			abort_q   <= 1'b0;
			pwr_cnt_q <= '0;
			pins_q    <= 3'b100;
		end
		else
		begin
			mode_q    <= mode_d;
			cnt_q     <= cnt_d;
			frame_q   <= frame_d;
			dummy_q   <= dummy_d;
			dout_q    <= dout_d;
			oe_q      <= oe_d;
			track_q   <= track_d;
			next_ch_q <= next_ch_d;
			conv_ch_q <= conv_ch_d;
			start_q   <= start_d;
			done_q    <= done_d;
			abort_q   <= abort_d;
			pwr_cnt_q <= pwr_cnt_d;
			pins_q    <= pins_s;
		end
	end

	assign dout_o       = dout_q;
	assign dout_oe_o    = oe_q;
	assign track_o      = track_q;
	// a dummy acquires the channel it just selected, not the older one
	assign acq_chan_o   = next_ch_q;
	assign analog_pwr_o = !(mode_q == ST_DOWN && !frame_q);
	assign pwr_ready_o  = (pwr_cnt_q == PWR_CNT_W'(PWR_UP_CYC));
	assign conv_start_o = start_q;
	assign conv_done_o  = done_q;
	assign conv_abort_o = abort_q;
	assign dummy_o      = dummy_q;
	assign mode_down_o  = (mode_q == ST_DOWN);
endmodule

// >>> adcpm_ctrl_properties.sv
`timescale 1ns/100ps
module adcpm_ctrl_properties (
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic cs_n_i,
	input wire logic dout_oe_o,
	input wire logic track_o,
	input wire logic analog_pwr_o,
	input wire logic pwr_ready_o,
	input wire logic conv_start_o,
	input wire logic conv_done_o,
	input wire logic conv_abort_o,
	input wire logic dummy_o,
	input wire logic mode_down_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);
	start_drive_a: assert property (conv_start_o |-> dout_oe_o && !track_o) else $error("start bad");
	start_lag_a: assert property ($fell(cs_n_i) |-> ##[2:5] conv_start_o) else $error("no start");
	pwr_off_a: assert property (!analog_pwr_o |=> !pwr_ready_o) else $error("ready unpowered");
	ready_lag_a: assert property ($rose(pwr_ready_o) |-> $past(analog_pwr_o, 99)) else $error("ready early");
	abort_rel_a: assert property (conv_abort_o |-> ##[0:1] !dout_oe_o) else $error("abort drives");
	done_valid_a: assert property (conv_done_o |-> !dummy_o && !mode_down_o) else $error("done in dummy");
	down_off_a: assert property ($rose(mode_down_o) |-> ##[0:1] (!analog_pwr_o && !dout_oe_o)) else $error("down on");
	rise_rel_a: assert property ($rose(cs_n_i) |-> ##[1:6] !dout_oe_o) else $error("output held");
	track_pwr_a: assert property ($rose(track_o) |-> analog_pwr_o) else $error("track unpowered");
	down_hold_a: assert property (mode_down_o && !analog_pwr_o |-> !track_o) else $error("track while down");
endmodule
bind adcpm_ctrl adcpm_ctrl_properties props_u (.*);

// >>> adcpm_ctrl_test.sv
`timescale 1ns/100ps
module adcpm_ctrl_test;
	localparam logic [11:0] conv_val = 12'ha5c;
	logic sys_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic cs_n, sclk, din, dout, oe, trk, chan, apwr, rdy, dmy, down;
	int   err_count = 0;
	int   n_tests = 0;
	always #5 sys_clk_i = ~sys_clk_i;
	adcpm_master m_u (.cs_n_o(cs_n), .sclk_o(sclk), .din_o(din), .dout_i(dout), .oe_i(oe));
	adcpm_ctrl #(.RES_BITS(12)) dut_u (
		.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .cs_n_i(cs_n), .sclk_i(sclk), .din_i(din),
		.conv_data_i(conv_val), .dout_o(dout), .dout_oe_o(oe), .track_o(trk), .acq_chan_o(chan),
		.analog_pwr_o(apwr), .pwr_ready_o(rdy), .conv_start_o(), .conv_done_o(), .conv_abort_o(),
		.dummy_o(dmy), .mode_down_o(down));
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic report_and_stop();
		$display("tests %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic cut(input int n);
		m_u.fall();
		m_u.clocks(n, 1'b0);
		m_u.rise();
	endtask
	task automatic t_wake(input logic ch);
		m_u.fall();
		m_u.clocks(4, ch);
		chk("track early", 0, trk);
		m_u.clocks(1, ch);
		chk("track fifth", 1, trk);
		m_u.clocks(11, ch);
		m_u.rise();
		chk("down", 0, down);
		chk("ready", 1, rdy);
		chk("chan", ch, chan);
	endtask
	task automatic t_norm(input logic prev, input logic ch);
		m_u.fall();
		m_u.clocks(16, ch);
		chk("track", 1, trk);
		m_u.rise();
		chk("word", {2'b00, prev, prev, conv_val}, m_u.word);
		chk("dummy", 0, dmy);
		chk("chan", ch, chan);
	endtask
	task automatic t_glitch();
		cut(1);
		chk("down", 0, down);
		chk("oe", 0, oe);
	endtask
	task automatic t_abort();
		cut(12);
		chk("down", 0, down);
		chk("pwr", 1, apwr);
		chk("oe", 0, oe);
	endtask
	task automatic t_pdown();
		cut(5);
		chk("down", 1, down);
		chk("pwr", 0, apwr);
		chk("oe", 0, oe);
	endtask
	task automatic t_burst();
		cut(8);
		chk("down", 1, down);
		chk("pwr", 0, apwr);
		chk("track down", 0, trk);
	endtask
	initial
	begin
		repeat (4) @(posedge sys_clk_i);
		#1 resetn_i = 1'b1;
		repeat (2) @(posedge sys_clk_i);
		#1;
		chk("rst", 16'h0012, {down, apwr, trk, dmy, oe});
		t_wake(1'b1);
		t_norm(1'b1, 1'b0);
		t_glitch();
		t_abort();
		t_pdown();
		t_burst();
		t_wake(1'b0);
		t_norm(1'b0, 1'b1);
		report_and_stop();
	end
	initial
	begin
		#100000;
		err_count++;
		report_and_stop();
	end
endmodule

// >>> adcpm_master.sv
`timescale 1ns/100ps
module adcpm_master (
	output logic      cs_n_o,
	output logic      sclk_o,
	output logic      din_o,
	input  wire logic dout_i,
	input  wire logic oe_i
);
	logic [15:0] word;
	initial
	begin
		cs_n_o = 1'b1;
		sclk_o = 1'b1;
		din_o = 1'b0;
	end
	task automatic fall();
		word = 16'h0000;
		cs_n_o = 1'b0;
		#62.5;
	endtask
	// a released output reads as unknown, so a missing drive never matches
	task automatic clocks(input int n, input logic ch);
		for (int k = 1; k <= n; k++)
		begin
			word = {word[14:0], oe_i ? dout_i : 1'bx};
			din_o = (k == 3) ? ch : ~ch;
			#20;
			sclk_o = 1'b0;
			#62.5;
			sclk_o = 1'b1;
			#42.5;
		end
	endtask
	task automatic rise();
		cs_n_o = 1'b1;
		#500;
	endtask
endmodule

// >>> adcpm_pkg.sv
package adcpm_pkg;

	// falling-edge counts, numbered from the chip select falling edge
	localparam int unsigned CNT_W           = 5;
	localparam logic [4:0]  CNT_MAX         = 5'h1F;
	localparam logic [4:0]  PD_LO_EDGE      = 5'h02;
	localparam logic [4:0]  KEEP_EDGE       = 5'h0A;
	localparam logic [4:0]  CHAN_EDGE       = 5'h03;
	localparam logic [4:0]  WAKE_TRACK_EDGE = 5'h05;
	localparam logic [4:0]  TRACK_EDGE      = 5'h0D;
	localparam logic [4:0]  DOUT_END_EDGE   = 5'h10;
	localparam logic [4:0]  FULL_UP_EDGE    = 5'h10;
	localparam logic [4:0]  CONV_EDGES_12   = 5'h10;
	localparam logic [4:0]  CONV_EDGES_10   = 5'h0E;

	// power-up time, rounded up to whole system clocks
	localparam int unsigned CLK_PERIOD_NS   = 10;
	localparam int unsigned POWER_UP_NS     = 1000;
	localparam int unsigned PWR_UP_CYC      = (POWER_UP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned PWR_CNT_W       = 8;

	// reset channel and output word top bit index
	localparam logic        RST_CHAN        = 1'b0;
	localparam logic [3:0]  WORD_TOP        = 4'hF;

	typedef enum logic [1:0] {
		ST_DOWN,
		ST_WAKE,
		ST_NORMAL
	} adcpm_mode_t;

	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic din;
	} adcpm_pins_t;

endpackage

// >>> adcpm_sync.sv
`timescale 1ns/100ps
module adcpm_sync #(
	parameter int unsigned WIDTH = 3
) (
	input  wire logic             sys_clk_i,
	input  wire logic             resetn_i,
	input  wire logic [WIDTH-1:0] async_i,
	input  wire logic [WIDTH-1:0] rst_val_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_d;

	// reset is synchronous, so loading a port value here is legal
	always_comb
	begin
		meta_d = resetn_i ? async_i : rst_val_i;
		sync_d = resetn_i ? meta_q : rst_val_i;
	end

	always_ff @(posedge sys_clk_i)
	begin
		meta_q <= meta_d;
		sync_q <= sync_d;
	end

	assign sync_o = sync_q;
endmodule
